/* File: design/apcs_pkg.sv */
/*
  Shared constants for the converter power and calibration sequencer:
  timing figures, derived cycle counts, control word layout, power
  modes, calibration kinds and the host register map.
  Assumes a 200 MHz system clock and a 6 MHz nominal master clock.
*/
package apcs_pkg;
  // Clock rates.
  localparam longint SYS_CLK_KHZ = 200_000;
  localparam longint REF_MCLK_KHZ = 6_000;
  localparam longint AUTO_MCLK_KHZ = 4_000;
  localparam longint NS_KHZ = 1_000_000;
  // Times in nanoseconds.
  localparam longint CAL_FULL_NS = 41_700_000;
  localparam longint CAL_GO_NS = 9_260_000;
  localparam longint CAL_ONE_NS = 4_630_000;
  localparam longint CONV_NS = 3_250;
  localparam longint AUTOCAL_NS = 32_000_000;
  localparam longint POR_TOTAL_NS = 35_000_000;
  localparam longint WAKE_NS = 5_000;
  localparam longint PWRUP_NS = 300_000;
  localparam longint INTREF_NS = 135_000_000;
  // Calibration and conversion lengths in master-clock cycles.
  localparam int CAL_FULL_MCLK = int'(CAL_FULL_NS * REF_MCLK_KHZ / NS_KHZ);
  localparam int CAL_GO_MCLK = int'(CAL_GO_NS * REF_MCLK_KHZ / NS_KHZ);
  localparam int CAL_ONE_MCLK = int'(CAL_ONE_NS * REF_MCLK_KHZ / NS_KHZ);
  localparam int CONV_MCLK =
    int'((CONV_NS * REF_MCLK_KHZ + NS_KHZ - 1) / NS_KHZ);
  localparam int AUTOCAL_MCLK = int'(AUTOCAL_NS * AUTO_MCLK_KHZ / NS_KHZ);
  // Lengths in system-clock cycles.
  localparam int POR_TIMEOUT_CYC =
    int'((POR_TOTAL_NS - AUTOCAL_NS) * SYS_CLK_KHZ / NS_KHZ);
  localparam int WAKE_CYC =
    int'((WAKE_NS * SYS_CLK_KHZ + NS_KHZ - 1) / NS_KHZ);
  localparam int PWRUP_CYC =
    int'((PWRUP_NS * SYS_CLK_KHZ + NS_KHZ - 1) / NS_KHZ);
  localparam int INTREF_CYC =
    int'((INTREF_NS * SYS_CLK_KHZ + NS_KHZ - 1) / NS_KHZ);
  localparam int MCLK_HALF_CYC =
    int'((SYS_CLK_KHZ + 2 * REF_MCLK_KHZ - 1) / (2 * REF_MCLK_KHZ));
  localparam int CNT_W = 32;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  // Control word carried on the link.
  localparam int CW_W = 6;
  localparam int CW_PM_LO = 0;
  localparam int CW_PM_HI = 1;
  localparam int CW_KIND_LSB = 2;
  localparam int CW_KIND_MSB = 4;
  localparam int CW_TRIM = 5;
  // Power-management codes {power_mgmt_hi, power_mgmt_lo}.
  localparam logic [1:0] PM_HW = 2'h0;
  localparam logic [1:0] PM_BETWEEN_FULL = 2'h1;
  localparam logic [1:0] PM_OFF = 2'h2;
  localparam logic [1:0] PM_BETWEEN_PART = 2'h3;
  // Calibration kinds: top bit selects the system family.
  localparam int KIND_SYS = 2;
  localparam logic [1:0] CK_FULL = 2'h0;
  localparam logic [1:0] CK_GAIN_OFFSET = 2'h1;
  localparam logic [2:0] KIND_RESET = 3'h0;
  // Host register map and fields.
  localparam int HR_W = 8;
  localparam logic [1:0] HREG_CTRL = 2'h0;
  localparam logic [1:0] HREG_CMD = 2'h1;
  localparam logic [1:0] HREG_STATUS = 2'h2;
  localparam int HC_LONG_IDLE = 5;
  localparam int HC_SLEEP = 6;
  localparam logic [HR_W-1:0] HCTRL_RESET = 8'h40;
  localparam int HCMD_WRITE = 0;
  localparam int HCMD_CONV = 1;
  localparam int HCMD_CAL = 2;
  localparam int HCMD_FINAL = 3;
  localparam int HCMD_W = 4;
  localparam logic [3:0] HOST_GAP_CYC = 4'h4;
endpackage : apcs_pkg

/* File: design/apcs_if.sv */
/*
  Link between the converter sequencer and its host controller.
  Holds plain wires; both ends run on the same system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface apcs_if;
  import apcs_pkg::*;
  logic master_clock_in;
  logic convert_start_n;
  logic cal_n;
  logic sleep_n;
  logic ctrl_wr;
  logic [CW_W-1:0] ctrl_word;
  logic busy;
  modport device (
    input master_clock_in, convert_start_n, cal_n, sleep_n,
    input ctrl_wr, ctrl_word,
    output busy
  );
  modport host (
    output master_clock_in, convert_start_n, cal_n, sleep_n,
    output ctrl_wr, ctrl_word,
    input busy
  );
endinterface : apcs_if
`default_nettype wire

/* File: design/apcs_device.sv */
/*
  Device end: power-on timeout and calibration, power-down modes,
  wake-up, conversion and calibration timing of a serial converter.
  Assumes link inputs are synchronous to sys_clk and that the host
  keeps its own timing obligations on the link.
*/
`timescale 1ns/1ps
`default_nettype none
module apcs_device import apcs_pkg::*; #(
  parameter int CAL_FULL_CYC = CAL_FULL_MCLK,
  parameter int CAL_GO_CYC = CAL_GO_MCLK,
  parameter int CAL_ONE_CYC = CAL_ONE_MCLK,
  parameter int AUTOCAL_CYC = AUTOCAL_MCLK,
  parameter int POR_TIMEOUT = POR_TIMEOUT_CYC
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link to the host.
  apcs_if.device link,
  // Device state.
  output logic core_on,
  output logic ref_on,
  output logic conv_done,
  output logic [2:0] cal_kind
);
  typedef enum logic [2:0] {
    S_POR_WAIT, S_POR_TIMEOUT, S_POR_CAL, S_IDLE,
    S_WAKE, S_CONV, S_CAL, S_DOWN
  } apcs_dev_state_type;

  apcs_dev_state_type state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [1:0] pm_reg;
  logic [2:0] kind_reg;
  logic mclk_q_reg, cnv_q_reg, cal_q_reg;
  logic busy_reg, core_on_reg, ref_on_reg, conv_done_reg;
  logic conv_done_next;

  // Edge detection on synchronous pins.
  wire mclk_rise = link.master_clock_in & ~mclk_q_reg;
  wire cnv_fall = cnv_q_reg & ~link.convert_start_n;
  wire cnv_rise = ~cnv_q_reg & link.convert_start_n;
  wire cal_rise = ~cal_q_reg & link.cal_n;
  wire ctrl_cal = link.ctrl_wr & link.ctrl_word[CW_TRIM];
  wire cal_start = cal_rise | ctrl_cal;

  // A software calibration uses the kind written with it.
  wire [2:0] kind_next = link.ctrl_wr ?
    link.ctrl_word[CW_KIND_MSB:CW_KIND_LSB] : kind_reg;
  wire [1:0] pm_next = link.ctrl_wr ?
    {link.ctrl_word[CW_PM_HI], link.ctrl_word[CW_PM_LO]} : pm_reg;

  // Power mode decode.
  wire pm_off = (pm_reg == PM_OFF);
  wire pd_between = (pm_reg == PM_HW && !link.sleep_n) ||
    pm_reg == PM_BETWEEN_FULL || pm_reg == PM_BETWEEN_PART;
  wire partial_next = (pm_next == PM_BETWEEN_PART);

  // Self and system families share the same lengths.
  wire [CNT_W-1:0] cal_len =
    (kind_next[1:0] == CK_FULL) ? CNT_W'(CAL_FULL_CYC) :
    (kind_next[1:0] == CK_GAIN_OFFSET) ? CNT_W'(CAL_GO_CYC) :
    CNT_W'(CAL_ONE_CYC);

  // Calibration and conversion count master-clock edges.
  wire mclk_paced = (state_reg == S_POR_CAL) ||
    (state_reg == S_CAL) || (state_reg == S_CONV);
  wire tick = mclk_paced ? mclk_rise : 1'b1;
  wire done = tick && (cnt_reg == CNT_ONE);
  wire [CNT_W-1:0] cnt_dec = tick ? cnt_reg - CNT_ONE : cnt_reg;
  wire apcs_dev_state_type after_cal = pm_off ? S_DOWN : S_IDLE;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_dec;
    conv_done_next = 1'b0;
    case (state_reg)
      S_POR_WAIT: begin
        if (link.ctrl_wr && !ctrl_cal) begin
          state_next = S_IDLE;
        end else if (cal_start) begin
          state_next = S_CAL;
          cnt_next = cal_len;
        end else if (cnv_rise) begin
          state_next = S_POR_TIMEOUT;
          cnt_next = CNT_W'(POR_TIMEOUT);
        end
      end
      S_POR_TIMEOUT: begin
        // Sleep and power modes are not consulted here.
        if (done) begin
          state_next = S_POR_CAL;
          cnt_next = CNT_W'(AUTOCAL_CYC);
        end
      end
      S_POR_CAL: begin
        // With sleep low the part may go down only once this ends.
        if (done) begin
          state_next = (pd_between || pm_off) ? S_DOWN : S_IDLE;
        end
      end
      S_IDLE: begin
        if (cal_start) begin
          state_next = S_CAL;
          cnt_next = cal_len;
        end else if (pm_off) begin
          state_next = S_DOWN;
        end else if (cnv_rise) begin
          state_next = S_CONV;
          cnt_next = CNT_W'(CONV_MCLK);
        end
      end
      S_DOWN: begin
        if (cal_start) begin
          state_next = S_CAL;
          cnt_next = cal_len;
        end else if (cnv_fall && pd_between) begin
          state_next = S_WAKE;
          cnt_next = CNT_W'(WAKE_CYC);
        end else if (!pm_off && !pd_between) begin
          state_next = S_WAKE;
          cnt_next = CNT_W'(WAKE_CYC);
        end
      end
      S_WAKE: begin
        // A rising edge inside the wake window is honoured, since the
        // host is expected to have held the pulse long enough.
        if (cal_start) begin
          state_next = S_CAL;
          cnt_next = cal_len;
        end else if (cnv_rise) begin
          state_next = S_CONV;
          cnt_next = CNT_W'(CONV_MCLK);
        end else if (done) begin
          state_next = S_IDLE;
        end
      end
      S_CONV: begin
        if (done) begin
          conv_done_next = 1'b1;
          state_next = (pd_between || pm_off) ? S_DOWN : S_IDLE;
        end
      end
      S_CAL: begin
        if (done) begin
          state_next = after_cal;
        end
      end
      default: begin
        state_next = S_POR_WAIT;
        cnt_next = CNT_ZERO;
      end
    endcase
  end

  wire busy_next = (state_next == S_POR_CAL) ||
    (state_next == S_CAL) || (state_next == S_CONV);
  wire core_next = (state_next != S_DOWN) && (state_next != S_WAKE);
  wire ref_next = (state_next != S_DOWN) || partial_next;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_POR_WAIT;
      cnt_reg <= CNT_ZERO;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pm_reg <= PM_HW;
      kind_reg <= KIND_RESET;
      mclk_q_reg <= 1'b0;
      cnv_q_reg <= 1'b1;
      cal_q_reg <= 1'b1;
    end else begin
      pm_reg <= pm_next;
      kind_reg <= kind_next;
      mclk_q_reg <= link.master_clock_in;
      cnv_q_reg <= link.convert_start_n;
      cal_q_reg <= link.cal_n;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
      core_on_reg <= 1'b1;
      ref_on_reg <= 1'b1;
      conv_done_reg <= 1'b0;
    end else begin
      busy_reg <= busy_next;
      core_on_reg <= core_next;
      ref_on_reg <= ref_next;
      conv_done_reg <= conv_done_next;
    end
  end

  assign link.busy = busy_reg;
  assign core_on = core_on_reg;
  assign ref_on = ref_on_reg;
  assign conv_done = conv_done_reg;
  assign cal_kind = kind_reg;
endmodule : apcs_device
`default_nettype wire

/* File: design/apcs_host.sv */
/*
  Host end: drives convert, calibrate, sleep and control writes,
  generates the master clock and keeps the host timing obligations.
  Software reaches it through a plain address/strobe register port.
*/
`timescale 1ns/1ps
`default_nettype none
module apcs_host import apcs_pkg::*; #(
  parameter bit USE_INTERNAL_REF = 1'b0,
  parameter int PWRUP_WAIT = PWRUP_CYC,
  parameter int INTREF_WAIT = INTREF_CYC
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Software register port.
  input wire logic [1:0] reg_addr,
  input wire logic [HR_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [HR_W-1:0] reg_rdata,
  // Link to the device.
  apcs_if.host link
);
  typedef enum logic [2:0] {
    H_START, H_IDLE, H_WR, H_CNV, H_CAL, H_GAP
  } apcs_host_state_type;

  apcs_host_state_type state_reg, state_next;
  logic [HR_W-1:0] ctrl_reg, rdata_reg;
  logic [HCMD_W-1:0] pend_reg, take;
  logic [CNT_W-1:0] cnt_reg, cnt_next, guard_reg;
  logic [CW_W-1:0] word_reg, word_next;
  logic wr_reg, cnv_n_reg, cal_n_reg, then_cnv_reg, then_cnv_next;
  logic por_act_reg, cancel_ok_reg, busy_q_reg, mclk_reg;
  logic [CNT_W-1:0] mclk_cnt_reg;

  wire ctrl_sel = reg_wr && reg_addr == HREG_CTRL;
  wire cmd_sel = reg_wr && reg_addr == HREG_CMD;
  wire [1:0] pm_cur = ctrl_reg[CW_PM_HI:CW_PM_LO];
  wire [CW_W-1:0] plain_word = {1'b0, ctrl_reg[CW_KIND_MSB:CW_PM_LO]};
  // Nothing new goes out while the device is busy.
  wire ready = !link.busy && !por_act_reg && !busy_q_reg;
  wire final_long = pend_reg[HCMD_FINAL] && ctrl_reg[HC_LONG_IDLE];
  wire [CW_W-1:0] part_word = {plain_word[CW_W-1:CW_PM_HI+1],
    PM_BETWEEN_PART};
  wire [CW_W-1:0] up_word = {plain_word[CW_W-1:CW_PM_HI+1],
    PM_BETWEEN_FULL};
  wire [1:0] status = {por_act_reg, guard_reg != CNT_ZERO};
  wire [HR_W-1:0] rd_mux =
    (reg_addr == HREG_CTRL) ? ctrl_reg :
    (reg_addr == HREG_CMD) ? {4'h0, pend_reg} :
    (reg_addr == HREG_STATUS) ?
      {4'h0, state_reg != H_IDLE, status, link.busy} : 8'h00;

  always_comb begin
    state_next = state_reg;
    cnt_next = (cnt_reg != CNT_ZERO) ? cnt_reg - CNT_ONE : CNT_ZERO;
    word_next = word_reg;
    then_cnv_next = then_cnv_reg;
    take = 4'h0;
    case (state_reg)
      H_START: begin
        // Early write cancels the power-on calibration.
        word_next = plain_word;
        state_next = USE_INTERNAL_REF ? H_WR : H_IDLE;
      end
      H_IDLE: begin
        then_cnv_next = 1'b0;
        if (ready && pend_reg[HCMD_WRITE]) begin
          take[HCMD_WRITE] = 1'b1;
          word_next = plain_word;
          state_next = H_WR;
        end else if (ready && (pend_reg[HCMD_CONV] ||
                               pend_reg[HCMD_FINAL])) begin
          take[HCMD_CONV] = 1'b1;
          take[HCMD_FINAL] = 1'b1;
          cnt_next = CNT_W'(WAKE_CYC);
          state_next = H_CNV;
          if (final_long || pm_cur == PM_OFF) begin
            word_next = final_long ? part_word : up_word;
            then_cnv_next = 1'b1;
            state_next = H_WR;
          end
        end else if (ready && pend_reg[HCMD_CAL] &&
                     guard_reg == CNT_ZERO) begin
          take[HCMD_CAL] = 1'b1;
          cnt_next = CNT_W'(WAKE_CYC);
          state_next = H_CAL;
        end
      end
      H_WR: begin
        // Each write is one whole word in one strobe.
        cnt_next = CNT_W'(WAKE_CYC);
        state_next = then_cnv_reg ? H_CNV : H_IDLE;
      end
      H_CNV: begin
        if (cnt_reg == CNT_ONE) begin
          cnt_next = CNT_W'(HOST_GAP_CYC);
          state_next = H_GAP;
        end
      end
      H_CAL: begin
        // Low long enough to cover a wake from power-down.
        if (cnt_reg == CNT_ONE) begin
          cnt_next = CNT_W'(HOST_GAP_CYC);
          state_next = H_GAP;
        end
      end
      H_GAP: begin
        // Lets busy rise before the next request is considered.
        if (cnt_reg == CNT_ONE) begin
          state_next = H_IDLE;
        end
      end
      default: begin
        state_next = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= H_START;
      cnt_reg <= CNT_ZERO;
      word_reg <= 6'h00;
      then_cnv_reg <= 1'b0;
      wr_reg <= 1'b0;
      cnv_n_reg <= 1'b1;
      cal_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      word_reg <= word_next;
      then_cnv_reg <= then_cnv_next;
      wr_reg <= (state_next == H_WR);
      cnv_n_reg <= (state_next != H_CNV);
      cal_n_reg <= (state_next != H_CAL);
    end
  end

  // A new command bit wins over the take in the same cycle.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= HCTRL_RESET;
      pend_reg <= 4'h0;
      rdata_reg <= 8'h00;
    end else begin
      if (ctrl_sel) ctrl_reg <= reg_wdata;
      pend_reg <= (pend_reg & ~take) |
        (cmd_sel ? reg_wdata[HCMD_W-1:0] : 4'h0);
      rdata_reg <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Power-on tracking and the calibration guard.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_act_reg <= 1'b0;
      cancel_ok_reg <= 1'b1;
      busy_q_reg <= 1'b0;
      guard_reg <= CNT_W'(USE_INTERNAL_REF ? INTREF_WAIT : 0);
    end else begin
      busy_q_reg <= link.busy;
      if (wr_reg && cancel_ok_reg) begin
        cancel_ok_reg <= 1'b0;
        guard_reg <= CNT_W'(USE_INTERNAL_REF ? INTREF_WAIT :
          PWRUP_WAIT);
      end else if (guard_reg != CNT_ZERO) begin
        guard_reg <= guard_reg - CNT_ONE;
      end
      if (state_reg == H_CNV && cancel_ok_reg) begin
        cancel_ok_reg <= 1'b0;
        por_act_reg <= 1'b1;
      end else if (busy_q_reg && !link.busy) begin
        por_act_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mclk_reg <= 1'b0;
      mclk_cnt_reg <= CNT_ZERO;
    end else if (mclk_cnt_reg == CNT_W'(MCLK_HALF_CYC - 1)) begin
      mclk_reg <= ~mclk_reg;
      mclk_cnt_reg <= CNT_ZERO;
    end else begin
      mclk_cnt_reg <= mclk_cnt_reg + CNT_ONE;
    end
  end

  assign reg_rdata = rdata_reg;
  assign link.master_clock_in = mclk_reg;
  assign link.convert_start_n = cnv_n_reg;
  assign link.cal_n = cal_n_reg;
  assign link.sleep_n = ctrl_reg[HC_SLEEP];
  assign link.ctrl_wr = wr_reg;
  assign link.ctrl_word = word_reg;
endmodule : apcs_host
`default_nettype wire

/* File: test/apcs_properties.sv */
/*
  Concurrent checks on the link between host and device ends.
  Assumes one system clock and that the bench instantiates it beside
  the link interface with the same shortened counts as the device.
*/
`timescale 1ns/1ps
`default_nettype none
module apcs_properties import apcs_pkg::*; #(
  parameter int CAL_FULL_CYC = CAL_FULL_MCLK,
  parameter int CAL_GO_CYC = CAL_GO_MCLK,
  parameter int CAL_ONE_CYC = CAL_ONE_MCLK,
  parameter int AUTOCAL_CYC = AUTOCAL_MCLK,
  parameter int POR_TIMEOUT = POR_TIMEOUT_CYC
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link signals.
  input wire logic master_clock_in,
  input wire logic convert_start_n,
  input wire logic cal_n,
  input wire logic ctrl_wr,
  input wire logic [CW_W-1:0] ctrl_word,
  input wire logic busy
);
  localparam int MP = 2 * MCLK_HALF_CYC;
  localparam int POR_LO = POR_TIMEOUT + (AUTOCAL_CYC - 1) * MP;
  localparam int POR_HI = POR_TIMEOUT + (AUTOCAL_CYC + 2) * MP;
  logic busy_q, mck_q, cnv_q, cal_q, pre_conv_reg, por_reg, src_conv_reg;
  logic [2:0] kind_reg;
  logic [31:0] mck_cnt, por_cnt, low_cnt;
  wire cnv_rise = convert_start_n && !cnv_q;
  wire cal_rise = cal_n && !cal_q;
  wire [31:0] cal_exp = (kind_reg[1:0] == 2'h0) ? 32'(CAL_FULL_CYC) :
    (kind_reg[1:0] == 2'h1) ? 32'(CAL_GO_CYC) : 32'(CAL_ONE_CYC);
  // Conversion and calibration busy lengths are counted in master-clock rises so they track its rate.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      mck_q <= 1'b0;
      cnv_q <= 1'b1;
      cal_q <= 1'b1;
      pre_conv_reg <= 1'b1;
      por_reg <= 1'b0;
      src_conv_reg <= 1'b0;
      kind_reg <= KIND_RESET;
      mck_cnt <= CNT_ZERO;
      por_cnt <= CNT_ZERO;
      low_cnt <= CNT_ZERO;
    end else begin
      busy_q <= busy;
      mck_q <= master_clock_in;
      cnv_q <= convert_start_n;
      cal_q <= cal_n;
      if (ctrl_wr || cnv_rise) pre_conv_reg <= 1'b0;
      if (cnv_rise && pre_conv_reg) por_reg <= 1'b1;
      else if (busy_q && !busy) por_reg <= 1'b0;
      if (cnv_rise) src_conv_reg <= 1'b1;
      else if (cal_rise) src_conv_reg <= 1'b0;
      if (ctrl_wr) kind_reg <= ctrl_word[CW_KIND_MSB:CW_KIND_LSB];
      if (busy && !busy_q) mck_cnt <= CNT_ZERO;
      else if (busy && master_clock_in && !mck_q) mck_cnt <= mck_cnt + CNT_ONE;
      por_cnt <= por_reg ? por_cnt + CNT_ONE : CNT_ZERO;
      low_cnt <= convert_start_n ? CNT_ZERO : low_cnt + CNT_ONE;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence busy_end_s;
    busy_q && !busy;
  endsequence
  sequence conv_go_s;
    cnv_rise && !busy && !pre_conv_reg && !por_reg;
  endsequence
  conv_start_a: assert property (conv_go_s |-> ##[1:3] busy)
    else $error("conversion start did not raise busy");
  conv_len_a: assert property (
    busy_end_s ##0 (src_conv_reg && !por_reg)
    |-> mck_cnt inside {[CONV_MCLK - 1:CONV_MCLK + 1]})
    else $error("conversion length wrong");
  cal_len_a: assert property (
    busy_end_s ##0 (!src_conv_reg && !por_reg)
    |-> mck_cnt + CNT_ONE >= cal_exp && mck_cnt <= cal_exp + CNT_ONE)
    else $error("calibration length wrong");
  por_len_a: assert property (busy_end_s ##0 por_reg
    |-> por_cnt >= 32'(POR_LO) && por_cnt <= 32'(POR_HI))
    else $error("power-on sequence length wrong");
  por_cancel_a: assert property (
    ctrl_wr && !ctrl_word[CW_TRIM] && pre_conv_reg |=> !busy [*8])
    else $error("cancelled power-on sequence still ran");
  cal_start_a: assert property (
    cal_rise && !busy && !pre_conv_reg && !por_reg |-> ##[1:3] busy)
    else $error("calibrate pulse did not raise busy");
  busy_hold_a: assert property ($rose(busy) |-> busy [*8])
    else $error("busy dropped early");
  convert_width_a: assert property (
    cnv_rise |-> low_cnt >= 32'(WAKE_CYC - 1))
    else $error("convert pulse too short");
endmodule : apcs_properties
`default_nettype wire

/* File: test/adc_power_and_calibration_sequencer_test.sv */
/*
  Self-checking bench joining host and device ends over the link.
  Assumes the package constants and shortened calibration counts.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_power_and_calibration_sequencer_test;
  import apcs_pkg::*;
  localparam int CF = 40;
  localparam int CG = 20;
  localparam int CO = 10;
  localparam int AC = 20;
  localparam int PT = 50;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [HR_W-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [HR_W-1:0] reg_rdata;
  logic core_on, ref_on, conv_done;
  logic [2:0] cal_kind;
  logic [31:0] rng = 32'h0001_50f4;
  logic [7:0] pmv [3] = '{8'h00, 8'h41, 8'h43};
  int fails = 0;
  int samples_checked = 0;
  int mr, dn, cd;
  always #2.5 sys_clk = ~sys_clk;
  apcs_if lnk();
  apcs_device #(.CAL_FULL_CYC(CF), .CAL_GO_CYC(CG), .CAL_ONE_CYC(CO),
    .AUTOCAL_CYC(AC), .POR_TIMEOUT(PT)) i_apcs_device (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(lnk), .core_on(core_on),
    .ref_on(ref_on), .conv_done(conv_done), .cal_kind(cal_kind));
  apcs_host #(.PWRUP_WAIT(100), .INTREF_WAIT(100)) i_apcs_host (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .link(lnk));
  apcs_properties #(.CAL_FULL_CYC(CF), .CAL_GO_CYC(CG), .CAL_ONE_CYC(CO),
    .AUTOCAL_CYC(AC), .POR_TIMEOUT(PT)) i_apcs_properties (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .master_clock_in(lnk.master_clock_in),
    .convert_start_n(lnk.convert_start_n), .cal_n(lnk.cal_n),
    .ctrl_wr(lnk.ctrl_wr), .ctrl_word(lnk.ctrl_word), .busy(lnk.busy));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic int cal_len(input logic [2:0] k);
    return (k[1:0] == 2'h0) ? CF : (k[1:0] == 2'h1) ? CG : CO;
  endfunction : cal_len
  task automatic chk(input string nm, input int ex, input logic [31:0] got,
    input int tol);
    samples_checked++;
    if ((^got === 1'bx) || int'(got) < ex - tol || int'(got) > ex + tol) begin
      fails++;
      $display("[ERR] %s expected %0d seen %0d", nm, ex, got);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] ex);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", ex, reg_rdata, 0);
  endtask : rd
  // Sampling on the falling edge keeps reads clear of the launching edge.
  task automatic run_cmd(input logic [7:0] c);
    int n;
    int t;
    logic mq;
    mr = 0;
    dn = 0;
    n = 0;
    mq = 1'b1;
    wr(HREG_CMD, c);
    while (lnk.busy !== 1'b1 && n < 4000) begin
      @(negedge sys_clk);
      n++;
      if (lnk.convert_start_n === 1'b0 && core_on === 1'b0) dn++;
    end
    t = n;
    n = 0;
    while (lnk.busy === 1'b1 && n < 4000) begin
      @(negedge sys_clk);
      n++;
      if (lnk.master_clock_in === 1'b1 && !mq) mr++;
      mq = lnk.master_clock_in;
    end
    cd = (conv_done === 1'b1);
    chk("busy_done", 1, 32'(t < 4000 && n < 4000), 0);
    repeat (10) @(negedge sys_clk);
  endtask : run_cmd
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (100000) @(posedge sys_clk);
    fails++;
    conclude();
  end
  initial begin : main
    logic [7:0] v;
    logic [2:0] k;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(2'h3, 8'h00);
    rd(HREG_CTRL, HCTRL_RESET);
    rng = xs(rng);
    v = {1'b0, rng[6:0]};
    wr(HREG_CTRL, v);
    rd(HREG_CTRL, v);
    wr(HREG_CTRL, 8'h40);
    wr(HREG_CMD, 8'h01);
    repeat (20) @(posedge sys_clk);
    run_cmd(8'h02);
    chk("conv_mclk", CONV_MCLK, mr, 1);
    chk("conv_done", 1, cd, 0);
    chk("core_on", 1, core_on, 0);
    $display("test cancel_conv done");
    k = rng[10:8];
    for (int i = 0; i < 8; i++) begin
      k = k + 3'h1;
      wr(HREG_CTRL, 8'h40 | {3'h0, k, 2'h0});
      wr(HREG_CMD, 8'h01);
      repeat (10) @(posedge sys_clk);
      run_cmd(8'h04);
      chk("cal_mclk", cal_len(k), mr, 1);
      chk("cal_kind", int'(k), cal_kind, 0);
      chk("cal_conv_done", 0, cd, 0);
    end
    $display("test calibrations done");
    // The first conversion after a mode change may start awake.
    for (int i = 0; i < 3; i++) begin
      wr(HREG_CTRL, pmv[i]);
      wr(HREG_CMD, 8'h01);
      repeat (10) @(posedge sys_clk);
      run_cmd(8'h02);
      run_cmd(8'h02);
      chk("wake_cyc", WAKE_CYC, dn, 3);
      chk("conv_mclk", CONV_MCLK, mr, 1);
      chk("core_on", 0, core_on, 0);
      chk("ref_on", int'(i == 2), ref_on, 0);
    end
    $display("test between_modes done");
    wr(HREG_CTRL, 8'h42);
    wr(HREG_CMD, 8'h01);
    repeat (20) @(negedge sys_clk);
    chk("core_on", 0, core_on, 0);
    wr(HREG_CTRL, 8'h40);
    wr(HREG_CMD, 8'h01);
    repeat (WAKE_CYC - 20) @(negedge sys_clk);
    chk("core_on", 0, core_on, 0);
    repeat (30) @(negedge sys_clk);
    chk("core_on", 1, core_on, 0);
    $display("test full_power_down done");
    wr(HREG_CTRL, 8'h42);
    wr(HREG_CMD, 8'h01);
    run_cmd(8'h02);
    chk("up_wake_cyc", WAKE_CYC, dn, 3);
    chk("up_conv_mclk", CONV_MCLK, mr, 1);
    wr(HREG_CTRL, 8'h60);
    run_cmd(8'h08);
    chk("final_conv_mclk", CONV_MCLK, mr, 1);
    chk("final_ref_on", 1, ref_on, 0);
    chk("final_core_on", 0, core_on, 0);
    $display("test host_power_cmds done");
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    wr(HREG_CTRL, 8'h00);
    run_cmd(8'h02);
    chk("por_core_off", 0, dn, 0);
    chk("por_mclk", AC + 1, mr, 2);
    chk("core_on", 0, core_on, 0);
    $display("test power_on done");
    conclude();
  end
endmodule : adc_power_and_calibration_sequencer_test
`default_nettype wire
